/* logic/adc_route_params.svh */
// constants for the converter input routing switch control
// assumes one 250 MHz clock; includers need nothing else from outside
`ifndef ADC_ROUTE_PARAMS_SVH
`define ADC_ROUTE_PARAMS_SVH
// register byte addresses
`define RT_CTRL_ADDR 12'h000
`define RT_CHAN_BASE 12'h080
`define RT_SWITCH_ADDR 12'h300
`define RT_OWNER_ADDR 12'h304
`define RT_CLOSED_ADDR 12'h308
`define RT_STATE_ADDR 12'h30c
`define RT_ZERO32 32'h0000_0000
`define RT_CHAN_RESET 32'h0000_0000
// global control word fields
`define RT_REF_MSB 6
`define RT_REF_LSB 4
`define RT_NEG_MSB 11
`define RT_NEG_LSB 9
`define RT_FAB_MODE 29
`define RT_BYPASS 30
// channel setup word fields
`define RT_DIFF_BIT 8
`define RT_PORT_MSB 6
`define RT_PORT_LSB 4
`define RT_PIN_MSB 2
`define RT_PIN_LSB 0
`define RT_PORT_PINS 3'h0
`define RT_PORT_SARBUS 3'h1
`define RT_PORT_INT 3'h7
`define RT_PIN_TEMP 3'h0
`define RT_PIN_BUSA 3'h2
`define RT_NEG_GND 3'h0
// switch numbers
`define RT_SW_MINUS_PIN 8
`define RT_SW_GND 16
`define RT_SW_TEMP 17
`define RT_SW_A_PLUS 18
`define RT_SW_B_PLUS 19
`define RT_SW_A_MINUS 20
`define RT_SW_B_MINUS 21
`define RT_SW_S0_PLUS 22
`define RT_SW_S1_PLUS 23
`define RT_SW_S0_MINUS 24
`define RT_SW_S1_MINUS 25
// fabric line positions
`define RT_FEN_PLUS 0
`define RT_FEN_MINUS 1
`define RT_FEN_S0 2
`define RT_FEN_S1 3
`define RT_FSW_GND 0
`define RT_FSW_TEMP 1
`endif

/* logic/adc_route_pkg.sv */
// types shared by the routing switch control and its decoder
// assumes adc_route_params.svh for all numbers
package adc_route_pkg;
  // fabric control lines, levels on the converter clock
  typedef struct packed {
    logic diff;
    logic [3:0] port_en;
    logic [1:0] sw_req;
  } fab_lines_t;
  // one register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } reg_req_t;
endpackage : adc_route_pkg

/* logic/seq_route_decode.sv */
// sequencer port/pin decode into route switch requests
// assumes a channel setup word and control fields from the same clock
`timescale 1ns/1ns
`default_nettype none
`include "adc_route_params.svh"
module seq_route_decode (
  input wire logic i_valid,
  input wire logic [31:0] i_chan_word,
  input wire logic [2:0] i_minus_choice,
  input wire logic i_diff,
  output logic [31:0] o_req
);
  import adc_route_pkg::*;

  wire [2:0] port = i_chan_word[`RT_PORT_MSB:`RT_PORT_LSB];
  wire [2:0] pin = i_chan_word[`RT_PIN_MSB:`RT_PIN_LSB];
  wire is_temp = (port == `RT_PORT_INT) && (pin == `RT_PIN_TEMP);
  wire is_bus = (port == `RT_PORT_INT) && (pin == `RT_PIN_BUSA);
  wire is_pin = (port == `RT_PORT_PINS);
  wire is_sar = (port == `RT_PORT_SARBUS);
  wire gnd_ok = !i_diff && (i_minus_choice == `RT_NEG_GND);
  wire [2:0] pin_plus = i_diff ? {pin[2:1], 1'b0} : pin;
  wire [2:0] pin_minus = {pin[2:1], 1'b1};

  // one plus and at most one minus switch per channel; the
  // reversed bus pair (19/20) has no code here on purpose
  always_comb begin
    o_req = `RT_ZERO32;
    if (i_valid) begin
      if (is_pin) begin
        o_req[pin_plus] = 1'b1;
        o_req[`RT_SW_MINUS_PIN + pin_minus] = i_diff;
      end
      if (is_sar) begin
        o_req[`RT_SW_S0_PLUS] = 1'b1;
        o_req[`RT_SW_S1_MINUS] = i_diff;
      end
      if (is_bus) begin
        o_req[`RT_SW_A_PLUS] = 1'b1;
        o_req[`RT_SW_B_MINUS] = i_diff;
      end
      if (is_temp) begin
        o_req[`RT_SW_TEMP] = 1'b1;
        o_req[`RT_SW_GND] = 1'b1;
      end else if (!is_bus || !i_diff) begin
        o_req[`RT_SW_GND] = gnd_ok;
      end
    end
  end
endmodule : seq_route_decode
`default_nettype wire

/* logic/adc_route_switch_control.sv */
// converter input routing switch control: registers, ownership and
// the three switch masters (sequencer, firmware, fabric)
// assumes sequencer and fabric lines come from logic on i_clk
`timescale 1ns/1ns
`default_nettype none
`include "adc_route_params.svh"
module adc_route_switch_control (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata,
  input wire logic i_seq_valid,
  input wire logic [2:0] i_seq_chan,
  input wire adc_route_pkg::fab_lines_t i_fab,
  output logic [31:0] o_switch_closed,
  output logic o_temp_sensor_en,
  output logic [2:0] o_minus_choice,
  output logic [2:0] o_ref_choice,
  output logic o_diff
);
  import adc_route_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // decode helpers

  // ownership bit that governs each switch; pin switches share one bit
  // per pin, the bus and converter-bus pairs share per bus
  function automatic logic [4:0] owner_of(input int sw);
    logic [4:0] r;
    r = 5'(sw);
    if (sw >= `RT_SW_MINUS_PIN && sw < `RT_SW_GND)
      r = 5'(sw - `RT_SW_MINUS_PIN);
    if (sw == `RT_SW_A_MINUS)
      r = 5'(`RT_SW_A_PLUS);
    if (sw == `RT_SW_B_MINUS)
      r = 5'(`RT_SW_B_PLUS);
    if (sw == `RT_SW_S0_MINUS)
      r = 5'(`RT_SW_S0_PLUS);
    if (sw == `RT_SW_S1_MINUS)
      r = 5'(`RT_SW_S1_PLUS);
    return r;
  endfunction : owner_of

  // fabric line that enables a switch under fabric ownership
  function automatic logic fab_en_of(input int sw, input fab_lines_t f);
    logic e;
    e = 1'b0;
    if (sw < `RT_SW_MINUS_PIN || sw == `RT_SW_A_PLUS ||
        sw == `RT_SW_B_PLUS)
      e = f.port_en[`RT_FEN_PLUS];
    if ((sw >= `RT_SW_MINUS_PIN && sw < `RT_SW_GND) ||
        sw == `RT_SW_A_MINUS || sw == `RT_SW_B_MINUS)
      e = f.port_en[`RT_FEN_MINUS] && f.diff;
    if (sw == `RT_SW_S0_PLUS)
      e = f.port_en[`RT_FEN_S0];
    if (sw == `RT_SW_S1_MINUS)
      e = f.port_en[`RT_FEN_S1] && f.diff;
    if (sw == `RT_SW_S1_PLUS)
      e = f.port_en[`RT_FEN_S1];
    if (sw == `RT_SW_S0_MINUS)
      e = f.port_en[`RT_FEN_S0] && f.diff;
    if (sw == `RT_SW_GND)
      e = f.sw_req[`RT_FSW_GND];
    if (sw == `RT_SW_TEMP)
      e = f.sw_req[`RT_FSW_TEMP];
    return e;
  endfunction : fab_en_of

  //////////////////////////////////////////////////////////////////////
  // register file

  localparam logic [11:0] CHAN_BASE = `RT_CHAN_BASE;
  reg_req_t req;
  logic [31:0] ctrl_r;
  logic [31:0] fw_r;
  logic [31:0] owner_r;
  logic [31:0] chan_r [8];
  logic [31:0] rdata_nxt;
  logic [31:0] state_word;
  logic [2:0] chan_idx;

  assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};
  wire chan_hit = (req.addr[11:5] == CHAN_BASE[11:5]) &&
                  (req.addr[1:0] == 2'h0);
  assign chan_idx = req.addr[4:2];
  wire ctrl_hit = (req.addr == `RT_CTRL_ADDR);
  wire sw_hit = (req.addr == `RT_SWITCH_ADDR);
  wire own_hit = (req.addr == `RT_OWNER_ADDR);
  wire closed_hit = (req.addr == `RT_CLOSED_ADDR);
  wire state_hit = (req.addr == `RT_STATE_ADDR);

  // writable words; all routing starts open after reset
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_r <= `RT_ZERO32;
      fw_r <= `RT_ZERO32;
      owner_r <= `RT_ZERO32;
    end else begin
      if (req.wr && ctrl_hit)
        ctrl_r <= req.wdata;
      if (req.wr && sw_hit)
        fw_r <= req.wdata;
      if (req.wr && own_hit)
        owner_r <= req.wdata;
    end
  end

  // eight channel setup words, one per sequencer slot
  generate
    for (genvar c = 0; c < 8; c++) begin : g_chan
      always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst)
          chan_r[c] <= `RT_CHAN_RESET;
        else if (req.wr && chan_hit && chan_idx == 3'(c))
          chan_r[c] <= req.wdata;
      end
    end
  endgenerate

  // read mux; unmapped addresses read zero
  assign state_word = {26'h0, o_diff, o_temp_sensor_en, 1'b0,
                       o_minus_choice};
  assign rdata_nxt = ctrl_hit ? ctrl_r :
                     sw_hit ? fw_r :
                     own_hit ? owner_r :
                     closed_hit ? o_switch_closed :
                     state_hit ? state_word :
                     chan_hit ? chan_r[chan_idx] : `RT_ZERO32;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst)
      o_rdata <= `RT_ZERO32;
    else
      o_rdata <= req.rd ? rdata_nxt : `RT_ZERO32;
  end

  //////////////////////////////////////////////////////////////////////
  // switch masters

  wire bypass = ctrl_r[`RT_BYPASS];
  wire fab_mode = ctrl_r[`RT_FAB_MODE];
  wire [2:0] neg_choice = ctrl_r[`RT_NEG_MSB:`RT_NEG_LSB];
  wire [31:0] seq_word = chan_r[i_seq_chan];
  // fabric mode overrides the channel's own differential bit
  wire diff_eff = fab_mode ? i_fab.diff :
                  seq_word[`RT_DIFF_BIT];
  logic [31:0] seq_req;
  logic [31:0] hw_src;
  logic [31:0] closed_nxt;

  // sequencer only acts while the bypass bit is clear
  seq_route_decode u_seq (
    .i_valid(i_seq_valid && !bypass),
    .i_chan_word(seq_word),
    .i_minus_choice(neg_choice),
    .i_diff(diff_eff),
    .o_req(seq_req)
  );

  // per switch: hardware source, then ownership choice; fabric lines
  // feed straight into the switch register so they act one edge later
  // and need no extra stage (they come from logic on this clock)
  generate
    for (genvar s = 0; s < 32; s++) begin : g_sw
      assign hw_src[s] = bypass ?
        (fab_mode && fw_r[s] && fab_en_of(s, i_fab)) :
        seq_req[s];
      assign closed_nxt[s] = owner_r[owner_of(s)] ? hw_src[s] :
                             fw_r[s];
    end
  endgenerate

  // sensor conversions force the minus choice to ground
  wire [2:0] minus_nxt = closed_nxt[`RT_SW_TEMP] ? `RT_NEG_GND :
                         neg_choice;

  // switch enables and derived outputs, all from flops
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_switch_closed <= `RT_ZERO32;
      o_minus_choice <= `RT_NEG_GND;
      o_diff <= 1'b0;
    end else begin
      o_switch_closed <= closed_nxt;
      o_minus_choice <= minus_nxt;
      o_diff <= diff_eff;
    end
  end

  // bias current follows the thermal plus switch itself
  assign o_temp_sensor_en = o_switch_closed[`RT_SW_TEMP];
  assign o_ref_choice = ctrl_r[`RT_REF_MSB:`RT_REF_LSB];

  //////////////////////////////////////////////////////////////////////
  // checks

  // the switch word is registered, so every check but AST_TEMP_MINUS looks one edge
  // after the inputs and registers that decide it; that one compares two flopped outputs
  wire [2:0] seq_port = seq_word[`RT_PORT_MSB:`RT_PORT_LSB];
  wire [2:0] seq_pin = seq_word[`RT_PIN_MSB:`RT_PIN_LSB];
  wire seq_on = i_seq_valid && !bypass;

  AST_TEMP_BIAS: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    !owner_r[`RT_SW_TEMP]
    |=> o_temp_sensor_en == $past(fw_r[`RT_SW_TEMP]))
    else $error("sensor bias does not follow thermal switch bit");

  AST_TEMP_MINUS: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    o_switch_closed[`RT_SW_TEMP] |-> o_minus_choice == `RT_NEG_GND)
    else $error("minus choice not forced during sensor routing");

  AST_SEQ_TEMP: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    seq_on && owner_r[`RT_SW_TEMP] && owner_r[`RT_SW_GND] &&
    seq_port == `RT_PORT_INT && seq_pin == `RT_PIN_TEMP
    |=> o_switch_closed[`RT_SW_TEMP] && o_switch_closed[`RT_SW_GND])
    else $error("sequencer did not route temperature sensor");

  AST_SEQ_BUS: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    seq_on && owner_r[`RT_SW_A_PLUS] && owner_r[`RT_SW_B_PLUS] &&
    seq_port == `RT_PORT_INT && seq_pin == `RT_PIN_BUSA && diff_eff
    |=> o_switch_closed[`RT_SW_A_PLUS] && o_switch_closed[`RT_SW_B_MINUS])
    else $error("sequencer bus pair not closed");

  AST_SE_NO_MINUS: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    seq_on && owner_r[`RT_SW_B_PLUS] && !diff_eff
    |=> !o_switch_closed[`RT_SW_B_MINUS])
    else $error("minus bus switch closed in single-ended mode");

  AST_SEQ_GND: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    seq_on && owner_r[`RT_SW_GND] && !diff_eff &&
    neg_choice == `RT_NEG_GND && seq_port == `RT_PORT_PINS
    |=> o_switch_closed[`RT_SW_GND])
    else $error("minus not grounded for single-ended channel");

  AST_NO_REVERSE: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    !bypass && owner_r[`RT_SW_A_PLUS] && owner_r[`RT_SW_B_PLUS]
    |=> !o_switch_closed[`RT_SW_B_PLUS] && !o_switch_closed[`RT_SW_A_MINUS])
    else $error("sequencer closed reversed bus pair");

  AST_BYPASS_FW: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    bypass && !fab_mode && owner_r[`RT_SW_S0_PLUS]
    |=> !o_switch_closed[`RT_SW_S0_PLUS])
    else $error("hardware-owned switch closed with no hardware master");

  AST_FW_OWN: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    !owner_r[`RT_SW_A_PLUS]
    |=> o_switch_closed[`RT_SW_A_PLUS] == $past(fw_r[`RT_SW_A_PLUS]))
    else $error("firmware-owned switch does not follow its bit");

  AST_FAB_EDGE: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    bypass && fab_mode && owner_r[`RT_SW_GND] && fw_r[`RT_SW_GND]
    |=> o_switch_closed[`RT_SW_GND] == $past(i_fab.sw_req[`RT_FSW_GND]))
    else $error("fabric ground request not taken at next edge");

  AST_FAB_DIFF: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    fab_mode |-> ##1 o_diff == $past(i_fab.diff))
    else $error("differential choice not taken from fabric");

  AST_SEQ_IDLE: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    !bypass && !i_seq_valid && owner_r[`RT_SW_S0_PLUS]
    |=> !o_switch_closed[`RT_SW_S0_PLUS])
    else $error("idle sequencer closed a hardware-owned switch");

  AST_SEQ_SAR: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    seq_on && owner_r[`RT_SW_S0_PLUS] && seq_port == `RT_PORT_SARBUS
    |=> o_switch_closed[`RT_SW_S0_PLUS])
    else $error("sequencer did not route converter bus 0");

  AST_FAB_PAIR: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    bypass && fab_mode && i_fab.diff && owner_r[`RT_SW_S0_PLUS] &&
    owner_r[`RT_SW_S1_PLUS] && fw_r[`RT_SW_S0_PLUS] &&
    fw_r[`RT_SW_S1_MINUS] && i_fab.port_en[`RT_FEN_S0] &&
    i_fab.port_en[`RT_FEN_S1]
    |=> o_switch_closed[`RT_SW_S0_PLUS] && o_switch_closed[`RT_SW_S1_MINUS])
    else $error("fabric pair on converter buses not closed");

  AST_MINUS_PASS: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    !o_switch_closed[`RT_SW_TEMP] |-> o_minus_choice == $past(neg_choice))
    else $error("minus choice changed outside sensor routing");

  AST_DIFF_CHAN: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    !fab_mode |=> o_diff == $past(seq_word[`RT_DIFF_BIT]))
    else $error("differential choice not taken from channel word");

endmodule : adc_route_switch_control
`default_nettype wire

/* testbench/fabric_lines_model.sv */
// fabric logic model: drives the fabric routing lines as levels
// assumes the same clock as the switch control and active-high reset
`timescale 1ns/1ns
`default_nettype none
`include "adc_route_params.svh"
module fabric_lines_model (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [1:0] i_op,
  output var adc_route_pkg::fab_lines_t o_fab
);
  import adc_route_pkg::*;
  fab_lines_t pat_nxt;
  ////////////////////////////////////////////////////////////////////////////
  // op 0 idle, 1 single-ended plus line with ground, 2 differential buses 0/1, 3 sensor
  // idle drops every line so no stale request keeps a switch closed
  always_comb begin
    pat_nxt = '0;
    case (i_op)
      2'h1: begin
        pat_nxt.port_en[`RT_FEN_PLUS] = 1'b1;
        pat_nxt.sw_req[`RT_FSW_GND] = 1'b1;
      end
      2'h2: begin
        pat_nxt.diff = 1'b1;
        pat_nxt.port_en[`RT_FEN_S0] = 1'b1;
        pat_nxt.port_en[`RT_FEN_S1] = 1'b1;
      end
      2'h3: begin
        // sensor only single-ended, ground on minus
        pat_nxt.sw_req = 2'h3;
      end
      default: pat_nxt = '0;
    endcase
  end
  // lines change just after an edge, like real fabric flops
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_fab <= '0;
    end else begin
      o_fab <= pat_nxt;
    end
  end
endmodule : fabric_lines_model
`default_nettype wire

/* testbench/tb_adc_route_switch_control.sv */
// testbench for the converter input routing switch control
// assumes the design files and the fabric lines model are compiled first
`timescale 1ns/1ns
`default_nettype none
`include "adc_route_params.svh"
module tb_adc_route_switch_control;
  import adc_route_pkg::*;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [11:0] i_addr = 12'h000;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_seq_valid = 1'b0;
  logic [2:0] i_seq_chan = 3'h0;
  logic [1:0] fab_op = 2'h0;
  fab_lines_t i_fab;
  wire logic [31:0] o_rdata;
  wire logic [31:0] o_switch_closed;
  wire logic o_temp_sensor_en;
  wire logic [2:0] o_minus_choice;
  wire logic [2:0] o_ref_choice;
  wire logic o_diff;
  int err_total = 0;
  int check_count = 0;
  ////////////////////////////////////////////////////////////////////////////
  // device under test and fabric side
  adc_route_switch_control adc_route_switch_control_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wr(i_wr), .i_rd(i_rd),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .i_seq_valid(i_seq_valid), .i_seq_chan(i_seq_chan), .i_fab(i_fab),
    .o_switch_closed(o_switch_closed), .o_temp_sensor_en(o_temp_sensor_en),
    .o_minus_choice(o_minus_choice), .o_ref_choice(o_ref_choice),
    .o_diff(o_diff));
  fabric_lines_model fabric_lines_model_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_op(fab_op), .o_fab(i_fab));
  // 250 MHz clock
  initial begin
    forever #2 i_clk = ~i_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // bus write: one strobe cycle, then released
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  // bus read: data only stands in the cycle after the strobe
  task rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask : rd
  // register changes reach the switches two edges later; allow three
  task settle();
    repeat (3) @(posedge i_clk);
    #1;
  endtask : settle
  task seq(input logic [2:0] ch, input logic [31:0] e);
    @(posedge i_clk);
    i_seq_chan <= ch;
    i_seq_valid <= 1'b1;
    settle();
    chk(o_switch_closed, e);
  endtask : seq
  task fab(input logic [1:0] op, input logic [31:0] e);
    @(posedge i_clk);
    fab_op <= op;
    settle();
    chk(o_switch_closed, e);
  endtask : fab
  task give_verdict();
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////
  // main sequence: reset, sequencer, firmware, fabric
  initial begin
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    #1 chk(o_switch_closed, 32'h0000_0000);
    rd(`RT_CLOSED_ADDR, 32'h0000_0000);
    wr(`RT_OWNER_ADDR, 32'h00cf_0003);
    rd(`RT_OWNER_ADDR, 32'h00cf_0003);
    wr(`RT_CHAN_BASE, 32'h0000_0072);
    wr(`RT_CHAN_BASE + 12'h004, 32'h0000_0172);
    wr(`RT_CHAN_BASE + 12'h008, 32'h0000_0070);
    wr(`RT_CHAN_BASE + 12'h00c, 32'h0000_0110);
    wr(`RT_CHAN_BASE + 12'h010, 32'h0000_0100);
    seq(3'h0, 32'h0005_0000);
    seq(3'h1, 32'h0024_0000);
    chk({31'h0, o_diff}, 32'h1);
    seq(3'h2, 32'h0003_0000);
    chk({31'h0, o_temp_sensor_en}, 32'h1);
    seq(3'h3, 32'h0240_0000);
    seq(3'h4, 32'h0000_0201);
    // nonzero minus choice; the sensor forces it to ground, reference stays zero
    wr(`RT_CTRL_ADDR, 32'h0000_0a00);
    seq(3'h2, 32'h0003_0000);
    chk({29'h0, o_minus_choice}, 32'h0);
    chk({29'h0, o_ref_choice}, 32'h0);
    wr(`RT_CTRL_ADDR, 32'h0000_0a30);
    seq(3'h0, 32'h0004_0000);
    chk({29'h0, o_minus_choice}, 32'h5);
    chk({29'h0, o_ref_choice}, 32'h3);
    @(posedge i_clk);
    i_seq_valid <= 1'b0;
    settle();
    chk(o_switch_closed, 32'h0000_0000);
    // firmware ownership with the sequencer bypassed
    wr(`RT_CTRL_ADDR, 32'h4000_0000);
    wr(`RT_SWITCH_ADDR, 32'h0018_0000);
    seq(3'h0, 32'h0000_0000);
    wr(`RT_OWNER_ADDR, 32'h0000_0000);
    settle();
    chk(o_switch_closed, 32'h0018_0000);
    wr(`RT_SWITCH_ADDR, 32'h0003_0000);
    settle();
    chk({31'h0, o_temp_sensor_en}, 32'h1);
    wr(`RT_SWITCH_ADDR, 32'h0001_0000);
    settle();
    chk({31'h0, o_temp_sensor_en}, 32'h0);
    // fabric ownership
    wr(`RT_CTRL_ADDR, 32'h6000_0000);
    wr(`RT_OWNER_ADDR, 32'h00cf_0003);
    wr(`RT_SWITCH_ADDR, 32'h0001_0001);
    fab(2'h1, 32'h0001_0001);
    chk({31'h0, o_diff}, 32'h0);
    wr(`RT_SWITCH_ADDR, 32'h0240_0000);
    fab(2'h2, 32'h0240_0000);
    chk({31'h0, o_diff}, 32'h1);
    // fabric line drop: model flop at the next edge, switches one later
    @(posedge i_clk);
    fab_op <= 2'h0;
    @(posedge i_clk);
    #1 chk(o_switch_closed, 32'h0240_0000);
    @(posedge i_clk);
    #1 chk(o_switch_closed, 32'h0000_0000);
    wr(`RT_SWITCH_ADDR, 32'h0003_0000);
    fab(2'h3, 32'h0003_0000);
    rd(`RT_STATE_ADDR, 32'h0000_0010);
    // unmapped place reads zero and ignores writes
    wr(12'h3f0, 32'h1234_5678);
    rd(12'h3f0, 32'h0000_0000);
    give_verdict();
  end
endmodule : tb_adc_route_switch_control
`default_nettype wire
